// *** src/fged_consts.vh ***
// Constants for the flash geometry and erase decoder.
`ifndef FGED_CONSTS_VH
`define FGED_CONSTS_VH
`define FGED_PAGE_BYTES 512
`define FGED_SECTOR_KB 64
`define FGED_SMALL_PAGES 16
`define FGED_MID_PAGES 96
`define FGED_SECTOR_PAGES 128
`define FGED_LOCK_PAGES 16
`define FGED_ECC_DATA_BITS 128
`define FGED_ECC_CHECK_BITS 9
`define FGED_CMD_W 3
`define FGED_CMD_WRITE_PAGE 3'h1
`define FGED_CMD_WRITE_PAGE_LOCK 3'h2
`define FGED_CMD_SECTOR_ERASE 3'h3
`define FGED_CMD_MULTI_PAGE 3'h4
`define FGED_CMD_WIPE 3'h5
`define FGED_ST_IDLE 2'h0
`define FGED_ST_ERASE 2'h1
`define FGED_ST_DONE 2'h2
`endif

// *** src/fged_ecc.v ***
// Single-error-correct, double-error-detect code over one 128-bit unit.
`timescale 1ns/1ns
`include "fged_consts.vh"
module fged_ecc #(
  parameter DW = `FGED_ECC_DATA_BITS,
  parameter CW = `FGED_ECC_CHECK_BITS
) (
  input wire [DW-1:0] wr_data,
  output wire [CW-1:0] wr_check,
  input wire [DW-1:0] rd_data,
  input wire [CW-1:0] rd_check,
  output wire [DW-1:0] fixed_data,
  output wire single_err,
  output wire double_err
);
  // Hamming positions: data bit i sits at the i-th non-power-of-two position.
  function [CW-2:0] posn;
    input integer idx;
    integer p, n;
    begin
      n = 0;
      posn = {(CW-1){1'b0}};
      for (p = 1; p < 256; p = p + 1) begin
        if ((p & (p - 1)) != 0) begin
          if (n == idx)
            posn = p[CW-2:0];
          n = n + 1;
        end
      end
    end
  endfunction

  function [CW-1:0] encode;
    input [DW-1:0] d;
    integer i;
    reg [CW-2:0] h;
    begin
      h = {(CW-1){1'b0}};
      for (i = 0; i < DW; i = i + 1)
        if (d[i])
          h = h ^ posn(i);
      encode = {^{h, d}, h};
    end
  endfunction

  wire [CW-1:0] recomputed;
  wire [CW-2:0] syndrome;
  wire parity_bad;
  assign wr_check = encode(wr_data);
  assign recomputed = encode(rd_data);
  assign syndrome = recomputed[CW-2:0] ^ rd_check[CW-2:0];
  assign parity_bad = ^{rd_data, rd_check};
  assign single_err = parity_bad;
  assign double_err = !parity_bad && (syndrome != {(CW-1){1'b0}});

  genvar g;
  generate
    for (g = 0; g < DW; g = g + 1) begin : gen_fix
      assign fixed_data[g] = rd_data[g] ^ (parity_bad && syndrome == posn(g));
    end
  endgenerate
endmodule // fged_ecc

// *** src/fged_decoder.v ***
// Flash plane geometry, erase-command decoding, locking and ECC read path.
// Contract
// - Every sector is whole 512-byte pages.
// - Plane divides into nominal 64 KB sectors.
// - First sector is 8, 8, 48 KB.
// - Pages 0-15 and 16-31 are small sectors.
// - Pages 32-127 form the 48 KB sector.
// - Later sectors are 128 pages each.
// - ECC per 128 bits: fix one, detect two.
// - Small-sector multi-page erase: code 0 four, 1 eight.
// - Large sectors: codes 1,2,3 erase 8,16,32 pages.
// - Sector erase wipes sector holding argument page.
// - Write-page erase commands allowed in small sectors.
// - Whole-plane wipe erases every page.
// - Other plane keeps reading during an erase.
// - 8 KB lock regions, each with lock bit.
`timescale 1ns/1ns
`include "fged_consts.vh"
module fged_decoder #(
  parameter PAGE_W = 11,
  parameter PLANES = 2,
  parameter DW = `FGED_ECC_DATA_BITS,
  parameter CW = `FGED_ECC_CHECK_BITS
) (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [`FGED_CMD_W-1:0] cmd_code,
  input wire [15:0] command_argument,
  input wire cmd_plane,
  input wire lock_set,
  input wire lock_clear,
  input wire [PAGE_W-1:0] lock_page,
  input wire lock_plane,
  input wire rd_valid,
  input wire rd_plane,
  input wire [DW-1:0] rd_data,
  input wire [CW-1:0] rd_check,
  output reg cmd_ready,
  output reg cmd_done,
  output reg cmd_error,
  output reg lock_error,
  output reg erase_valid,
  output reg erase_plane,
  output reg [PAGE_W-1:0] erase_page,
  output reg rd_ok,
  output reg [DW-1:0] rd_out,
  output reg rd_corrected,
  output reg rd_uncorrectable,
  output reg [PLANES-1:0] plane_busy
);
  localparam PAGES = 1 << PAGE_W;
  localparam REGIONS = PAGES / `FGED_LOCK_PAGES;
  localparam [PAGE_W:0] SMALL_CNT = `FGED_SMALL_PAGES;
  localparam [PAGE_W:0] MID_CNT = `FGED_MID_PAGES;
  localparam [PAGE_W:0] SECTOR_CNT = `FGED_SECTOR_PAGES;
  localparam [PAGE_W:0] WIPE_CNT = PAGES;
  localparam [PAGE_W:0] MP_BASE = 4;
  localparam [PAGE_W-1:0] MID_START = 2 * `FGED_SMALL_PAGES;
  localparam [1:0] ST_IDLE = `FGED_ST_IDLE;
  localparam [1:0] ST_ERASE = `FGED_ST_ERASE;
  localparam [1:0] ST_DONE = `FGED_ST_DONE;

  // Sequencer state lives up here because the lock bits read it.
  reg [1:0] state;
  reg [PAGE_W-1:0] run_start;
  reg [PAGE_W:0] run_left;
  reg run_plane;
  reg run_lock_write;
  reg run_wipe;
  reg [PAGE_W-1:0] erase_cursor;
  reg pend_lock;

  // ----------------------------------------------------------------
  // Lock bits
  // ----------------------------------------------------------------
  reg [REGIONS-1:0] lock_bits [0:PLANES-1];
  integer k;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < PLANES; k = k + 1)
        lock_bits[k] <= {REGIONS{1'b0}};
    end else begin
      if (lock_set || lock_clear)
        lock_bits[lock_plane][lock_page[PAGE_W-1:4]] <= lock_set;
      // A lock that a finished run writes beats a clear in the same cycle.
      if (run_lock_write)
        lock_bits[run_plane][run_start[PAGE_W-1:4]] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [PAGE_W-1:0] arg_page = command_argument[PAGE_W+1:2];
  wire [PAGE_W-1:0] full_page = command_argument[PAGE_W-1:0];
  wire [1:0] arg_code = command_argument[1:0];
  // Page 0..31 are the two small sectors; 32..127 the mid one; rest full.
  wire in_first = (full_page[PAGE_W-1:7] == {(PAGE_W-7){1'b0}});
  wire mp_small = (arg_page[PAGE_W-1:5] == {(PAGE_W-5){1'b0}});
  reg [PAGE_W-1:0] dec_start;
  reg [PAGE_W:0] dec_count;
  reg dec_bad;
  reg dec_lockw;
  always @* begin
    dec_start = full_page;
    dec_count = {{PAGE_W{1'b0}}, 1'b1};
    dec_bad = 1'b0;
    dec_lockw = 1'b0;
    case (cmd_code)
      `FGED_CMD_WRITE_PAGE, `FGED_CMD_WRITE_PAGE_LOCK: begin
        dec_bad = !(full_page < 2 * `FGED_SMALL_PAGES);
        dec_lockw = (cmd_code == `FGED_CMD_WRITE_PAGE_LOCK);
      end
      `FGED_CMD_SECTOR_ERASE: begin
        if (in_first && full_page[6:5] == 2'h0) begin
          dec_start = {full_page[PAGE_W-1:4], 4'h0};
          dec_count = SMALL_CNT;
        end else if (in_first) begin
          dec_start = MID_START;
          dec_count = MID_CNT;
        end else begin
          dec_start = {full_page[PAGE_W-1:7], 7'h00};
          dec_count = SECTOR_CNT;
        end
      end
      `FGED_CMD_MULTI_PAGE: begin
        if (mp_small && arg_code[1]) begin
          dec_bad = 1'b1;
        end else if (!mp_small && arg_code == 2'h0) begin
          dec_bad = 1'b1;
        end else begin
          dec_count = MP_BASE << arg_code;
          case (arg_code)
            2'h0: dec_start = {arg_page[PAGE_W-1:2], 2'h0};
            2'h1: dec_start = {arg_page[PAGE_W-1:3], 3'h0};
            2'h2: dec_start = {arg_page[PAGE_W-1:4], 4'h0};
            default: dec_start = {arg_page[PAGE_W-1:5], 5'h00};
          endcase
        end
      end
      `FGED_CMD_WIPE: begin
        dec_start = {PAGE_W{1'b0}};
        dec_count = WIPE_CNT;
      end
      default: dec_bad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Erase sequencer: one page per cycle to the array
  // ----------------------------------------------------------------
  wire cur_locked = lock_bits[run_plane][erase_cursor[PAGE_W-1:4]];
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      run_start <= {PAGE_W{1'b0}};
      run_left <= {(PAGE_W+1){1'b0}};
      run_plane <= 1'b0;
      run_lock_write <= 1'b0;
      run_wipe <= 1'b0;
      erase_cursor <= {PAGE_W{1'b0}};
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      lock_error <= 1'b0;
      erase_valid <= 1'b0;
      erase_plane <= 1'b0;
      erase_page <= {PAGE_W{1'b0}};
      plane_busy <= {PLANES{1'b0}};
    end else begin
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      lock_error <= 1'b0;
      erase_valid <= 1'b0;
      run_lock_write <= 1'b0;
      case (state)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            if (dec_bad) begin
              cmd_error <= 1'b1;
              cmd_done <= 1'b1;
            end else begin
              run_start <= dec_start;
              erase_cursor <= dec_start;
              run_left <= dec_count;
              run_plane <= cmd_plane;
              run_wipe <= (cmd_code == `FGED_CMD_WIPE);
              run_lock_write <= 1'b0;
              plane_busy[cmd_plane] <= 1'b1;
              state <= ST_ERASE;
            end
          end
        end
        ST_ERASE: begin
          // A locked region aborts the run; the wipe ignores locks.
          if (cur_locked && !run_wipe) begin
            lock_error <= 1'b1;
            state <= ST_DONE;
          end else begin
            erase_valid <= 1'b1;
            erase_plane <= run_plane;
            erase_page <= erase_cursor;
            erase_cursor <= erase_cursor + {{(PAGE_W-1){1'b0}}, 1'b1};
            run_left <= run_left - {{PAGE_W{1'b0}}, 1'b1};
            if (run_left == {{PAGE_W{1'b0}}, 1'b1})
              state <= ST_DONE;
          end
        end
        default: begin
          plane_busy <= {PLANES{1'b0}};
          cmd_done <= 1'b1;
          run_lock_write <= pend_lock && !lock_error;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Remember a lock-after-write request through the run.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      pend_lock <= 1'b0;
    else if (state == ST_IDLE && cmd_valid && cmd_ready)
      pend_lock <= !dec_bad && dec_lockw;
  end

  // ----------------------------------------------------------------
  // Read path: served on any plane not erasing, even while the other erases
  // ----------------------------------------------------------------
  wire [DW-1:0] fixed;
  wire s_err;
  wire d_err;
  fged_ecc #(.DW(DW), .CW(CW)) u_ecc (
    .wr_data({DW{1'b0}}),
    .wr_check(),
    .rd_data(rd_data),
    .rd_check(rd_check),
    .fixed_data(fixed),
    .single_err(s_err),
    .double_err(d_err)
  );
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ok <= 1'b0;
      rd_out <= {DW{1'b0}};
      rd_corrected <= 1'b0;
      rd_uncorrectable <= 1'b0;
    end else begin
      rd_ok <= rd_valid && !plane_busy[rd_plane];
      rd_out <= fixed;
      rd_corrected <= rd_valid && s_err;
      rd_uncorrectable <= rd_valid && d_err;
    end
  end
endmodule // fged_decoder

// *** bench/fged_decoder_assertions.sv ***
// Port-level assertions for the flash erase decoder.
`timescale 1ns/1ns
`include "fged_consts.vh"
module fged_decoder_assertions #(
  parameter PAGE_W = 11
) (
  input wire core_clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [`FGED_CMD_W-1:0] cmd_code,
  input wire [15:0] command_argument,
  input wire cmd_ready,
  input wire cmd_done,
  input wire cmd_error,
  input wire lock_error,
  input wire erase_valid,
  input wire erase_plane,
  input wire [PAGE_W-1:0] erase_page,
  input wire rd_valid,
  input wire rd_plane,
  input wire rd_ok,
  input wire [1:0] plane_busy
);
  // ----------
  // Decoded view of the command being taken
  // ----------
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire acc = cmd_valid && cmd_ready;
  wire [PAGE_W:0] mp = {1'b0, command_argument[PAGE_W+1:2]};
  wire [PAGE_W:0] sp = {1'b0, command_argument[PAGE_W-1:0]};
  wire [1:0] k = command_argument[1:0];
  wire sml = mp < 12'h20;
  wire mpe = acc && cmd_code == `FGED_CMD_MULTI_PAGE;
  wire good = sml ? !k[1] : k != 2'h0;
  wire sec = acc && cmd_code == `FGED_CMD_SECTOR_ERASE;
  wire wpe = acc && (cmd_code == `FGED_CMD_WRITE_PAGE || cmd_code == `FGED_CMD_WRITE_PAGE_LOCK);
  wire wbig = sp >= 12'h20;
  wire [PAGE_W:0] bsz = 12'h4 << k;
  wire [PAGE_W:0] sbase = sp < 12'h10 ? 12'h0 : sp < 12'h20 ? 12'h10 : sp < 12'h80 ? 12'h20 : sp & 12'hf80;
  wire [PAGE_W:0] algn = sec ? sbase : mp & ~(bsz - 12'h1);
  reg on;
  reg lk;
  reg [PAGE_W:0] want;
  reg [PAGE_W:0] seen;
  // Pages are counted per run so a dropped or repeated page shows at completion.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      on <= 1'b0;
      lk <= 1'b0;
      want <= 12'h0;
      seen <= 12'h0;
    end else if ((mpe && good) || sec || (acc && cmd_code == `FGED_CMD_WIPE)) begin
      on <= 1'b1;
      lk <= 1'b0;
      want <= sec ? (sp < 12'h20 ? 12'h10 : sp < 12'h80 ? 12'h60 : 12'h80) : mpe ? bsz : 12'h800;
      seen <= 12'h0;
    end else begin
      on <= on && !cmd_done;
      lk <= lk || lock_error;
      seen <= seen + (erase_valid ? 12'h1 : 12'h0);
    end
  end
  sequence refused_s;
    cmd_error && cmd_done ##1 !erase_valid;
  endsequence
  sequence run4_s;
    erase_valid [*4] ##1 cmd_done && !erase_valid;
  endsequence
  err_with_done_a: assert property (cmd_error |-> cmd_done) else $error("error without done");
  bad_code_a: assert property (mpe && !good |=> refused_s) else $error("bad code taken");
  wp_range_a: assert property (wpe |=> cmd_error == $past(wbig)) else $error("write page range");
  small_run_a: assert property (mpe && sml && k == 2'h0 |-> (##2 run4_s) or (##[1:6] lock_error))
    else $error("four page run");
  page_count_a: assert property (on && cmd_done && !lk && !lock_error |-> seen == want)
    else $error("page count");
  first_page_a: assert property ((mpe && good) || sec |-> ##2 (!erase_valid || erase_page == $past(algn, 2)))
    else $error("first page");
  page_step_a: assert property (erase_valid && $past(erase_valid) |-> erase_page == $past(erase_page) + 1'b1)
    else $error("page step");
  plane_busy_a: assert property (erase_valid |-> plane_busy[erase_plane] && !plane_busy[!erase_plane])
    else $error("busy plane");
  read_free_a: assert property (rd_valid && !plane_busy[rd_plane] |=> rd_ok) else $error("read blocked");
endmodule // fged_decoder_assertions
bind fged_decoder fged_decoder_assertions #(.PAGE_W(PAGE_W)) chk (.*);

// *** bench/fged_requester.sv ***
// Bus-master model that issues flash commands to the decoder.
`timescale 1ns/1ns
module fged_requester (
  input wire core_clk,
  input wire cmd_ready,
  output reg cmd_valid = 1'b0,
  output reg [2:0] cmd_code = 3'h0,
  output reg [15:0] command_argument = 16'h0,
  output reg cmd_plane = 1'b0
);
  // Fields flip after hand-over so a stale command can never look live.
  task issue(input [2:0] code, input [15:0] arg, input pl, input integer gap, output reg ok);
    integer i;
    begin
      ok = 1'b0;
      repeat (gap) @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      command_argument <= arg;
      cmd_plane <= pl;
      for (i = 0; i < 64 && !ok; i = i + 1) begin
        @(posedge core_clk);
        ok = cmd_ready;
      end
      cmd_valid <= 1'b0;
      cmd_code <= ~code;
      command_argument <= ~arg;
      cmd_plane <= ~pl;
    end
  endtask
endmodule // fged_requester

// *** bench/tb_flash_geometry_erase_decoder.sv ***
// Self-checking bench for the flash geometry and erase decoder.
`timescale 1ns/1ns
`include "fged_consts.vh"
module tb_flash_geometry_erase_decoder;
  localparam [2:0] c_wp = `FGED_CMD_WRITE_PAGE;
  localparam [2:0] c_se = `FGED_CMD_SECTOR_ERASE;
  localparam [2:0] c_mp = `FGED_CMD_MULTI_PAGE;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg lock_set = 1'b0;
  reg lock_clear = 1'b0;
  reg [10:0] lock_page = 11'h0;
  reg lock_plane = 1'b0;
  reg rd_valid = 1'b0;
  reg rd_plane = 1'b0;
  reg [127:0] rd_data = 128'h0;
  reg [8:0] rd_check = 9'h0;
  wire cmd_valid, cmd_plane, cmd_ready, cmd_done, cmd_error, lock_error, erase_valid, erase_plane;
  wire rd_ok, rd_corrected, rd_uncorrectable;
  wire [2:0] cmd_code;
  wire [15:0] command_argument;
  wire [10:0] erase_page;
  wire [127:0] rd_out;
  wire [1:0] plane_busy;
  integer n_mismatch = 0;
  integer n_checks = 0;
  fged_decoder dut (.*);
  fged_requester req (.*);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  task chk(input c, input [8*12-1:0] m);
    begin
      n_checks = n_checks + 1;
      if (c !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t: %0s", $time, m);
      end
    end
  endtask
  // A count of 12'hfff skips the page check where the run length is not fixed.
  task run(input [2:0] c, input [15:0] a, input p, input [11:0] n, input [10:0] f, input e);
    integer i;
    integer nr;
    reg ok, d, er;
    reg [11:0] cnt;
    reg [10:0] fp;
    begin
      {d, er, cnt, fp, nr} = 0;
      rd_plane <= !p;
      rd_valid <= 1'b1;
      req.issue(c, a, p, n_checks % 2, ok);
      // A refusal stands only in the cycle after the taking edge, so look before waiting.
      for (i = 0; i < 3000 && !d; i = i + 1) begin
        #1;
        if (erase_valid === 1'b1 && cnt == 0) fp = erase_page;
        cnt = cnt + erase_valid;
        er = er | cmd_error | lock_error;
        nr = nr + rd_ok;
        d = cmd_done;
        @(posedge core_clk);
      end
      @(posedge core_clk);
      if (!d) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0t: hang", $time);
        end_sim;
      end
      chk(ok && er === e, "status");
      if (n != 12'hfff) chk(cnt === n && (n == 0 || fp === f), "pages");
      if (n != 12'hfff && !e) chk(nr != 0, "read");
    end
  endtask
  task lock(input s, input [10:0] pg, input pl);
    begin
      lock_set <= s;
      lock_clear <= !s;
      lock_page <= pg;
      lock_plane <= pl;
      @(posedge core_clk);
      lock_set <= 1'b0;
      lock_clear <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task t_sector;
    begin
      run(c_se, 16'h5, 1'b0, 12'h10, 11'h0, 1'b0);
      run(c_se, 16'h14, 1'b1, 12'h10, 11'h10, 1'b0);
      run(c_se, 16'h7f, 1'b0, 12'h60, 11'h20, 1'b0);
      run(c_se, 16'h1ab, 1'b1, 12'h80, 11'h180, 1'b0);
      $display("sector test done");
    end
  endtask
  task t_multi;
    begin
      run(c_mp, 16'h54, 1'b0, 12'h4, 11'h14, 1'b0);
      run(c_mp, 16'h55, 1'b1, 12'h8, 11'h10, 1'b0);
      run(c_mp, 16'h56, 1'b0, 12'h0, 11'h0, 1'b1);
      run(c_mp, 16'h57, 1'b1, 12'h0, 11'h0, 1'b1);
      run(3'h0, 16'h5, 1'b0, 12'h0, 11'h0, 1'b1);
      run(3'h7, 16'h5, 1'b1, 12'h0, 11'h0, 1'b1);
      run(c_mp, 16'h320, 1'b0, 12'h0, 11'h0, 1'b1);
      run(c_mp, 16'h321, 1'b1, 12'h8, 11'hc8, 1'b0);
      run(c_mp, 16'h322, 1'b0, 12'h10, 11'hc0, 1'b0);
      run(c_mp, 16'h323, 1'b1, 12'h20, 11'hc0, 1'b0);
      $display("multi-page test done");
    end
  endtask
  task t_lock;
    begin
      run(c_wp, 16'ha, 1'b0, 12'hfff, 11'h0, 1'b0);
      run(c_wp, 16'h28, 1'b0, 12'hfff, 11'h0, 1'b1);
      run(`FGED_CMD_WRITE_PAGE_LOCK, 16'h3, 1'b1, 12'hfff, 11'h0, 1'b0);
      run(c_se, 16'h3, 1'b1, 12'hfff, 11'h0, 1'b1);
      lock(1'b0, 11'h3, 1'b1);
      run(c_se, 16'h3, 1'b1, 12'h10, 11'h0, 1'b0);
      lock(1'b1, 11'h28, 1'b0);
      run(c_se, 16'h32, 1'b0, 12'hfff, 11'h0, 1'b1);
      run(c_mp, 16'hc1, 1'b0, 12'h8, 11'h30, 1'b0);
      run(c_se, 16'h32, 1'b1, 12'h60, 11'h20, 1'b0);
      lock(1'b0, 11'h28, 1'b0);
      $display("lock test done");
    end
  endtask
  task t_wipe;
    begin
      run(`FGED_CMD_WIPE, 16'h0, 1'b1, 12'h800, 11'h0, 1'b0);
      $display("wipe test done");
    end
  endtask
  // An all-zero word with zero check bits is a valid code word whatever the bit placement.
  task ecc_one(input [127:0] dv, input [8:0] cv, input s, input u);
    begin
      rd_valid <= 1'b1;
      rd_data <= dv;
      rd_check <= cv;
      @(posedge core_clk);
      #1;
      chk(rd_corrected === s && rd_uncorrectable === u && (u || rd_out === 128'h0), "ecc");
      @(posedge core_clk);
    end
  endtask
  task t_ecc;
    begin
      ecc_one(128'h0, 9'h000, 1'b0, 1'b0);
      ecc_one(128'h1, 9'h000, 1'b1, 1'b0);
      ecc_one({1'b1, 127'h0}, 9'h000, 1'b1, 1'b0);
      ecc_one(128'h0, 9'h001, 1'b1, 1'b0);
      ecc_one(128'h0, 9'h100, 1'b1, 1'b0);
      ecc_one(128'h3, 9'h000, 1'b0, 1'b1);
      ecc_one(128'h1, 9'h001, 1'b0, 1'b1);
      $display("ecc test done");
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_sector;
    t_multi;
    t_lock;
    t_wipe;
    t_ecc;
    end_sim;
  end
endmodule // tb_flash_geometry_erase_decoder
